// [hdl/hler_map.vh]
// Notes on behaviour
// - later link errors land in the next-error log; several flags may stand.
// - first-error log holds one flag until cleared; later errors go next.
// - bit 6 set on a system error received from the link.
// - bit 5 set on invalid address to be master aborted, reply or not.
// - bit 4 set when own cycle ends in target-abort completion.
// - bit 3 set on single-bit header/address error, correction on or off.
// - bit 2 set on single-bit data error, correction on or off.
// - bit 1 reports uncorrectable header/address error; zero means none.
// - bit 0 set on multi-bit data error, correction on or off.
// - system-error mask enables bits 5:0 only; bits 7:6 reserved.
// - management interrupt when enabled flag set in either log.
// - zero system-error enable suppresses it; enables reset to zero.
// - zero management enable suppresses it; enables reset to zero.
// - event interrupt when an event-mask bit and its flag in either log are set.
`ifndef HLER_MAP_VH
`define HLER_MAP_VH
`define HLER_OFS_FIRST 8'h80
`define HLER_OFS_NEXT 8'h82
`define HLER_OFS_SERR 8'ha0
`define HLER_OFS_SMI 8'ha2
`define HLER_OFS_SCI 8'ha4
`define HLER_LOG_MASK 8'h7f
`define HLER_SERR_MASK 8'h3f
`define HLER_ROUTE_MASK 8'h7f
`define HLER_RESET_VAL 8'h00
`define HLER_BIT_LINK_SERR 6
`define HLER_BIT_MABORT 5
`define HLER_BIT_TABORT 4
`define HLER_BIT_CE_HDR 3
`define HLER_BIT_CE_DATA 2
`define HLER_BIT_UE_HDR 1
`define HLER_BIT_UE_DATA 0
`endif

// [hdl/hler_log.v]
`include "hler_map.vh"

module hler_log
#(
    parameter WIDTH = 8
)
(
    input wire clk,
    input wire pwr_rst_n,
    input wire [WIDTH-1:0] err_set,
    input wire [WIDTH-1:0] clr_mask,
    input wire clr_we,
    input wire first_mode,
    output reg [WIDTH-1:0] flags
);

    // ***************************************
    // sticky w1c log; set beats clear, but in first_mode a clear wins over an error while flags are nonzero
    // ***************************************
    wire [WIDTH-1:0] kept;
    wire [WIDTH-1:0] set_eff;
    reg [WIDTH-1:0] lowest;
    wire [WIDTH-1:0] next_flags;
    integer i;

    assign kept = clr_we ? (flags & ~clr_mask) : flags;

    // first-error log picks one bit, only while empty
    always @*
    begin
        lowest = {WIDTH{1'b0}};
        for (i = WIDTH - 1; i >= 0; i = i - 1)
        begin
            if (err_set[i])
            begin
                lowest = {WIDTH{1'b0}};
                lowest[i] = 1'b1;
            end
        end
    end

    assign set_eff = first_mode ? ((flags == {WIDTH{1'b0}}) ? lowest
        : {WIDTH{1'b0}}) : err_set;
    assign next_flags = (kept | set_eff) & `HLER_LOG_MASK;

    // only power-up reset touches the logs
    always @(posedge clk)
    begin
        if (!pwr_rst_n)
            flags <= `HLER_RESET_VAL;
        else
            flags <= next_flags;
    end

endmodule // hler_log

// [hdl/hler_top.v]
`include "hler_map.vh"

module hler_top
#(
    parameter WIDTH = 8
)
(
    input wire clk,
    input wire rst_n,
    input wire pwr_rst_n,
    input wire ev_link_serr,
    input wire ev_master_abort,
    input wire ev_target_abort,
    input wire ev_ce_header,
    input wire ev_ce_data,
    input wire ev_ue_header,
    input wire ev_ue_data,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    output reg [7:0] cfg_rdata,
    output wire system_error,
    output wire mgmt_interrupt,
    output wire event_interrupt
);

    // ***************************************
    // event collection
    // ***************************************
    wire [WIDTH-1:0] err_evt;
    wire [WIDTH-1:0] first_flags;
    wire [WIDTH-1:0] next_set;
    wire [WIDTH-1:0] link_next_error_log;
    reg [7:0] system_error_route_mask;
    reg [7:0] mgmt_interrupt_route_mask;
    reg [7:0] event_interrupt_route_mask;
    wire wr_first;
    wire wr_next;
    wire [WIDTH-1:0] any_log;

    assign err_evt[7] = 1'b0;
    assign err_evt[`HLER_BIT_LINK_SERR] = ev_link_serr;
    assign err_evt[`HLER_BIT_MABORT] = ev_master_abort;
    assign err_evt[`HLER_BIT_TABORT] = ev_target_abort;
    assign err_evt[`HLER_BIT_CE_HDR] = ev_ce_header;
    assign err_evt[`HLER_BIT_CE_DATA] = ev_ce_data;
    assign err_evt[`HLER_BIT_UE_HDR] = ev_ue_header;
    assign err_evt[`HLER_BIT_UE_DATA] = ev_ue_data;

    // ***************************************
    // logs
    // ***************************************
    assign wr_first = cfg_wr && (cfg_addr == `HLER_OFS_FIRST);
    assign wr_next = cfg_wr && (cfg_addr == `HLER_OFS_NEXT);

    // errors the first log takes do not also land in the next log
    assign next_set = (first_flags == {WIDTH{1'b0}}) ?
        (err_evt & ~first_take(err_evt)) : err_evt;

    function [WIDTH-1:0] first_take;
        input [WIDTH-1:0] e;
        integer k;
        begin
            first_take = {WIDTH{1'b0}};
            for (k = WIDTH - 1; k >= 0; k = k - 1)
            begin
                if (e[k])
                begin
                    first_take = {WIDTH{1'b0}};
                    first_take[k] = 1'b1;
                end
            end
        end
    endfunction

    hler_log #(.WIDTH(WIDTH)) u_first
    (
        .clk(clk),
        .pwr_rst_n(pwr_rst_n),
        .err_set(err_evt),
        .clr_mask(cfg_wdata),
        .clr_we(wr_first),
        .first_mode(1'b1),
        .flags(first_flags)
    );

    hler_log #(.WIDTH(WIDTH)) u_next
    (
        .clk(clk),
        .pwr_rst_n(pwr_rst_n),
        .err_set(next_set),
        .clr_mask(cfg_wdata),
        .clr_we(wr_next),
        .first_mode(1'b0),
        .flags(link_next_error_log)
    );

    // ***************************************
    // address decode
    // ***************************************
    wire hit_serr;
    wire hit_smi;
    wire hit_sci;
    wire wr_serr;
    wire wr_smi;
    wire wr_sci;

    // one write strobe per mapped mask register
    assign hit_serr = (cfg_addr == `HLER_OFS_SERR);
    assign hit_smi = (cfg_addr == `HLER_OFS_SMI);
    assign hit_sci = (cfg_addr == `HLER_OFS_SCI);
    assign wr_serr = cfg_wr && hit_serr;
    assign wr_smi = cfg_wr && hit_smi;
    assign wr_sci = cfg_wr && hit_sci;

    // ***************************************
    // routing masks
    // ***************************************
    reg [7:0] next_serr_mask;
    reg [7:0] next_smi_mask;
    reg [7:0] next_sci_mask;

    // reserved mask bits never store a one
    always @*
    begin
        next_serr_mask = system_error_route_mask;
        next_smi_mask = mgmt_interrupt_route_mask;
        next_sci_mask = event_interrupt_route_mask;
        if (wr_serr)
        begin
            next_serr_mask = cfg_wdata & `HLER_SERR_MASK;
        end
        if (wr_smi)
        begin
            next_smi_mask = cfg_wdata & `HLER_ROUTE_MASK;
        end
        if (wr_sci)
        begin
            next_sci_mask = cfg_wdata & `HLER_ROUTE_MASK;
        end
    end

    // masks follow rst_n only, not the power-up reset the logs use
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            system_error_route_mask <= `HLER_RESET_VAL;
            mgmt_interrupt_route_mask <= `HLER_RESET_VAL;
            event_interrupt_route_mask <= `HLER_RESET_VAL;
        end
        else
        begin
            system_error_route_mask <= next_serr_mask;
            mgmt_interrupt_route_mask <= next_smi_mask;
            event_interrupt_route_mask <= next_sci_mask;
        end
    end

    // ***************************************
    // read path
    // ***************************************
    reg [7:0] next_cfg_rdata;

    // unmapped offsets read as zero
    always @*
    begin
        next_cfg_rdata = cfg_rdata;
        if (cfg_rd)
        begin
            case (cfg_addr)
                `HLER_OFS_FIRST: next_cfg_rdata = first_flags;
                `HLER_OFS_NEXT: next_cfg_rdata = link_next_error_log;
                `HLER_OFS_SERR: next_cfg_rdata = system_error_route_mask;
                `HLER_OFS_SMI: next_cfg_rdata = mgmt_interrupt_route_mask;
                `HLER_OFS_SCI: next_cfg_rdata = event_interrupt_route_mask;
                default: next_cfg_rdata = 8'h00;
            endcase
        end
    end

    // read data stand until the next read
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_rdata <= 8'h00;
        end
        else
        begin
            cfg_rdata <= next_cfg_rdata;
        end
    end

    // ***************************************
    // message routing
    // ***************************************
    wire [WIDTH-1:0] serr_hit;
    wire [WIDTH-1:0] smi_hit;
    wire [WIDTH-1:0] sci_hit;
    genvar g;

    assign any_log = first_flags | link_next_error_log;

    // one enable term per flag position
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_route
            assign serr_hit[g] = any_log[g] & system_error_route_mask[g];
            assign smi_hit[g] = any_log[g] & mgmt_interrupt_route_mask[g];
            assign sci_hit[g] = any_log[g] & event_interrupt_route_mask[g];
        end
    endgenerate

    // no exclusivity check: software keeps one message type per flag
    assign system_error = |serr_hit;
    assign mgmt_interrupt = |smi_hit;
    assign event_interrupt = |sci_hit;

endmodule // hler_top

// [test/hler_bridge_model.sv]
module hler_bridge_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic [6:0] req,
    output logic [6:0] ev
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] p1 = 7'h00;
    logic [6:0] p2 = 7'h00;
    initial ev = 7'h00;
    always @(posedge clk)
    begin
        p1 <= req;
        p2 <= p1;
    end
    // one-cycle fault pulses, prompt or one cycle late
    always @(negedge clk)
        ev <= slow ? p2 : p1;
endmodule // hler_bridge_model

// [test/hler_top_props.sv]
module hler_top_props (
    input wire clk,
    input wire rst_n,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    input wire [7:0] cfg_rdata,
    input wire system_error,
    input wire mgmt_interrupt,
    input wire event_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_rd(a);
        cfg_wr && cfg_addr == a ##1 cfg_rd && !cfg_wr && cfg_addr == a;
    endsequence
    a_quiet_reset: assert property (disable iff (1'b0)
        !rst_n |=> !(system_error || mgmt_interrupt || event_interrupt))
        else $error("output active after reset");
    a_rdata_reset: assert property (disable iff (1'b0)
        !rst_n |=> cfg_rdata == 8'h00) else $error("read data not cleared");
    a_serr_readback: assert property (s_wr_rd(8'ha0)
        |=> cfg_rdata == ($past(cfg_wdata, 2) & 8'h3f))
        else $error("bad serr mask");
    a_mgmt_readback: assert property (s_wr_rd(8'ha2)
        |=> cfg_rdata == ($past(cfg_wdata, 2) & 8'h7f))
        else $error("bad mgmt mask");
    a_event_readback: assert property (s_wr_rd(8'ha4)
        |=> cfg_rdata == ($past(cfg_wdata, 2) & 8'h7f))
        else $error("bad event mask");
    a_log_bit7: assert property (cfg_rd && cfg_addr[7:2] == 6'h20
        |=> !cfg_rdata[7]) else $error("reserved log bit set");
    a_unmapped_zero: assert property (cfg_rd && cfg_addr[0]
        |=> cfg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved");
endmodule // hler_top_props

bind hler_top hler_top_props i_props (.*);

// [test/tb_hler_top.sv]
module tb_hler_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, pwr_rst_n = 0, cfg_wr = 0, cfg_rd = 0;
    logic slow = 0, rd_pend = 0, serr, mgmt, evt;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, a, cfg_rdata;
    logic [6:0] req = 7'h00, ev;
    logic [7:0] exp_q[$];
    logic [7:0] ofs[5] = '{8'h80, 8'h82, 8'ha0, 8'ha2, 8'ha4};
    logic [7:0] msk[5] = '{8'h7f, 8'h7f, 8'h3f, 8'h7f, 8'h7f};
    logic [31:0] seed = 30;
    int fails = 0, num_checks = 0, cyc = 0;
    hler_top i_dut (.clk(clk), .rst_n(rst_n), .pwr_rst_n(pwr_rst_n),
        .ev_link_serr(ev[6]), .ev_master_abort(ev[5]),
        .ev_target_abort(ev[4]), .ev_ce_header(ev[3]), .ev_ce_data(ev[2]),
        .ev_ue_header(ev[1]), .ev_ue_data(ev[0]), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .system_error(serr),
        .mgmt_interrupt(mgmt), .event_interrupt(evt));
    hler_bridge_model i_link (.clk(clk), .slow(slow), .req(req), .ev(ev));
    initial forever #2.5 clk = ~clk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] e);
        num_checks++;
        if (got !== e)
        begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, e);
        end
    endtask
    task automatic chk_out(logic [2:0] e);
        num_checks++;
        if ({serr, mgmt, evt} !== e)
        begin
            fails++;
            $display("[ERR] %0t outputs %b want %b", $time,
                {serr, mgmt, evt}, e);
        end
    endtask
    task automatic wr(logic [7:0] ad, logic [7:0] d);
        cfg_wr = 1;
        cfg_addr = ad;
        cfg_wdata = d;
        @(posedge clk) cfg_wr <= 0;
        @(negedge clk);
    endtask
    task automatic rd(logic [7:0] ad, logic [7:0] e);
        exp_q.push_back(e);
        cfg_rd = 1;
        cfg_addr = ad;
        @(posedge clk) cfg_rd <= 0;
        @(negedge clk);
    endtask
    task automatic fire(logic [6:0] b);
        req = b;
        @(posedge clk) req <= 7'h00;
        repeat (4) @(negedge clk);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) rd_pend <= cfg_rd;
    always @(negedge clk) if (rd_pend) chk(cfg_rdata, exp_q.pop_front());
    always @(posedge clk) if (++cyc == 2000)
    begin
        fails++;
        results();
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        pwr_rst_n = 1;
        for (int i = 0; i < 5; i++) rd(ofs[i], 8'h00);
        for (int i = 2; i < 5; i++)
        begin
            a = rnd();
            wr(ofs[i], a);
            rd(ofs[i], a & msk[i]);
            wr(ofs[i], 8'h00);
        end
        a = rnd() | 8'h01;
        wr(a, rnd());
        rd(a, 8'h00);
        fire(7'h10);
        for (int i = 0; i < 7; i++)
        begin
            slow = i[0];
            fire(7'h01 << i);
        end
        rd(8'h80, 8'h10);
        rd(8'h82, 8'h7f);
        wr(8'h82, 8'h10);
        rd(8'h82, 8'h6f);
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 7; i++)
            begin
                wr(ofs[k + 2], 8'h01 << i);
                chk_out(k == 0 ? {i < 6, 2'b00} : 3'b100 >> k);
                wr(ofs[k + 2], 8'h00);
            end
        chk_out(3'b000);
        wr(8'ha2, 8'h7f);
        rst_n = 0;
        @(negedge clk) rst_n = 1;
        chk_out(3'b000);
        rd(8'h82, 8'h6f);
        wr(8'h80, 8'hff);
        wr(8'h82, 8'hff);
        rd(8'h80, 8'h00);
        rd(8'h82, 8'h00);
        fire(7'h0c);
        rd(8'h80, 8'h04);
        rd(8'h82, 8'h08);
        req = 7'h08;
        @(posedge clk) req <= 7'h00;
        @(negedge clk);
        wr(8'h82, 8'h08);
        rd(8'h82, 8'h08);
        wr(8'h82, 8'h08);
        rd(8'h82, 8'h00);
        @(negedge clk);
        results();
    end
endmodule // tb_hler_top
